// ---- pkg/tbp_consts.svh ----
// timing and reset constants for the ten bit pwm generator
`ifndef TBP_CONSTS_SVH
`define TBP_CONSTS_SVH
`define TBP_NUM_TIMERS 3
`define TBP_PERIOD_RST 8'hFF
`define TBP_DUTY_RST 10'h000
`define TBP_PRESCALE_1 2'h0
`define TBP_PRESCALE_4 2'h1
`define TBP_PRESCALE_16 2'h2
`define TBP_PRESCALE_64 2'h3
`define TBP_PHASE_COUNT 2'h3
`endif

// ---- pkg/tbp_pkg.sv ----
// types shared by the pwm generator files
package tbp_pkg;
    typedef logic [1:0] tbp_sel_t;
    typedef logic [9:0] tbp_duty_t;
endpackage

// ---- pkg/tbp_tick_if.sv ----
// time base bundle carried from a timer to the pwm core
interface tbp_tick_if;
    logic [9:0] base;
    logic roll;
    logic match;
    modport timer (output base, output roll, output match);
    modport core (input base, input roll, input match);
endinterface

// ---- design/tbp_timer.sv ----
// one 8-bit auto-reload timer extended to a 10-bit time base
`include "tbp_consts.svh"
module tbp_timer
    import tbp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic sleep,
    input wire logic [1:0] prescale,
    input wire logic [7:0] period,
    tbp_tick_if.timer tick
);
    typedef struct packed {
        logic [7:0] count;
        logic [5:0] pre;
    } tbp_tmr_s;
    tbp_tmr_s st_reg, st_next;
    logic [5:0] pre_top;
    logic inc;
    logic step;
    always_comb begin
        unique case (prescale)
            `TBP_PRESCALE_1: pre_top = 6'h03;
            `TBP_PRESCALE_4: pre_top = 6'h0F;
            `TBP_PRESCALE_16: pre_top = 6'h3F;
            default: pre_top = 6'h3F;
        endcase
    end
    // timer steps once per four osc periods times prescale, 1:64 only as often as 1:16
    assign inc = run && !sleep && (st_reg.pre == pre_top);
    always_comb begin
        st_next = st_reg;
        if (run && !sleep) begin
            st_next.pre = (st_reg.pre == pre_top) ? 6'h00 : st_reg.pre + 6'h01;
            if (inc) begin
                st_next.count = (st_reg.count == period) ? 8'h00 : st_reg.count + 8'h01;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    // low two bits: clock phase at 1:1, else top prescaler bits
    always_comb begin
        unique case (prescale)
            `TBP_PRESCALE_1: tick.base = {st_reg.count, st_reg.pre[1:0]};
            `TBP_PRESCALE_4: tick.base = {st_reg.count, st_reg.pre[3:2]};
            default: tick.base = {st_reg.count, st_reg.pre[5:4]};
        endcase
    end
    assign tick.roll = inc && (st_reg.count == period);
    // base moves on this edge: every cycle at 1:1, else when the phase bits below it wrap
    always_comb begin
        unique case (prescale)
            `TBP_PRESCALE_1: step = 1'b1;
            `TBP_PRESCALE_4: step = (st_reg.pre[1:0] == 2'h3);
            default: step = (st_reg.pre[3:0] == 4'hF);
        endcase
    end
    assign tick.match = run && !sleep && step;
endmodule // tbp_timer

// ---- design/tbp_pwm.sv ----
// ten bit pwm generator with three selectable timers
`include "tbp_consts.svh"
module tbp_pwm
    import tbp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sleep,
    input wire logic [2:0] timer_run_bit,
    input wire logic [5:0] timer_prescale_select,
    input wire logic [23:0] period_register,
    input wire logic [1:0] timer_source_select,
    input wire logic [7:0] duty_high_byte,
    input wire logic [7:0] duty_low_bits,
    input wire logic module_enable_bit,
    input wire logic output_polarity_bit,
    input wire logic pin_direction_bit,
    input wire logic timebase_flag_clear,
    output logic [2:0] timebase_match_flag,
    output logic [7:0] timebase_counter,
    output logic pulse_output_pin,
    output logic pulse_output_oe
);
    tbp_tick_if tk [`TBP_NUM_TIMERS] ();
    logic [9:0] bases [`TBP_NUM_TIMERS];
    logic [2:0] rolls;
    logic [2:0] steps;
    genvar g;
    generate
        for (g = 0; g < `TBP_NUM_TIMERS; g++) begin : g_tmr
            tbp_timer u_tmr (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .run(timer_run_bit[g]),
                .sleep(sleep),
                .prescale(timer_prescale_select[2*g+1:2*g]),
                .period(period_register[8*g+7:8*g]),
                .tick(tk[g])
            );
            assign bases[g] = tk[g].base;
            assign rolls[g] = tk[g].roll;
            assign steps[g] = tk[g].match;
        end
    endgenerate

    typedef struct packed {
        logic [9:0] duty_value;
        logic level;
        logic [2:0] flags;
    } tbp_state_s;
    tbp_state_s st_reg, st_next;
    tbp_sel_t sel;
    logic [9:0] base;
    logic roll;
    logic step;
    logic [7:0] per;
    tbp_duty_t duty_value_buffer;
    logic past_period;

    // time base source per module
    assign sel = (timer_source_select == 2'h3) ? 2'h0 : timer_source_select;
    assign base = bases[sel];
    assign roll = rolls[sel];
    assign step = steps[sel];
    assign per = period_register[8*sel+7 -: 8];
    assign duty_value_buffer = {duty_high_byte, duty_low_bits[7:6]};
    // duty beyond 4*period+3 can never be reached by the base
    assign past_period = st_reg.duty_value > {per, 2'h3};
    // duty ratio follows from clearing at duty within 4*(period+1) base units

    always_comb begin
        st_next = st_reg;
        // flag set wins over a software clear
        if (timebase_flag_clear) begin
            st_next.flags = 3'h0;
        end
        st_next.flags = st_next.flags | rolls;
        if (roll) begin
            st_next.duty_value = duty_value_buffer;
            if (duty_value_buffer != `TBP_DUTY_RST) begin
                st_next.level = 1'b1;
            end else begin
                st_next.level = 1'b0;
            end
        end else if (!past_period && step && base + 10'h001 == st_reg.duty_value) begin
            st_next.level = 1'b0;
        end
        if (st_reg.duty_value == 10'h000 && !roll) begin
            st_next.level = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else if (!sleep) begin
            st_reg <= st_next;
        end
    end

    assign timebase_match_flag = st_reg.flags;
    assign timebase_counter = base[9:2];
    // polarity sets the active level; disabled module drives inactive
    assign pulse_output_pin = (module_enable_bit & st_reg.level) ^ output_polarity_bit;
    assign pulse_output_oe = !pin_direction_bit && !sys_rst;

    a_flag_on_roll: assert property (@(posedge clk_sys) disable iff (sys_rst)
        roll && !sleep |=> timebase_match_flag[sel])
        else $error("match flag not set at rollover");
    a_duty_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
        roll && !sleep |=> st_reg.duty_value == $past(duty_value_buffer))
        else $error("duty not latched at rollover");
    a_duty_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !roll |=> $stable(st_reg.duty_value))
        else $error("duty changed between rollovers");
    a_level_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
        roll && !sleep && duty_value_buffer != 10'h000 |=> st_reg.level)
        else $error("output not set at rollover");
    a_zero_duty: assert property (@(posedge clk_sys) disable iff (sys_rst)
        roll && !sleep && duty_value_buffer == 10'h000 |=> !st_reg.level)
        else $error("output set with zero duty");
    a_sleep_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sleep |=> $stable(st_reg))
        else $error("state moved in sleep");
    a_polarity_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !module_enable_bit |-> pulse_output_pin == output_polarity_bit)
        else $error("idle level ignores polarity");
    a_long_duty: assert property (@(posedge clk_sys) disable iff (sys_rst)
        past_period && !roll |=> st_reg.level == $past(st_reg.level))
        else $error("pin toggled with duty beyond period");
    a_level_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !past_period && !roll && step && base + 10'h001 == st_reg.duty_value
        |=> !st_reg.level)
        else $error("output not cleared at duty");
    a_reset_input: assert property (@(posedge clk_sys)
        sys_rst |-> !pulse_output_oe)
        else $error("pin driven during reset");
endmodule // tbp_pwm

// ---- testbench/tbp_load.sv ----
// load model that times the pulses seen on the output pin
module tbp_load (
    input wire logic clk_sys,
    input wire logic pin,
    input wire logic oe,
    output int high_len,
    output int period_len
);
    timeunit 1ns;
    timeprecision 1ns;
    int hc = 0;
    int pc = 0;
    logic last = 1'b0;
    initial begin
        high_len = 0;
        period_len = 0;
    end
    always @(posedge clk_sys) begin
        if (oe && pin && !last) begin
            period_len <= pc;
            pc <= 1;
            hc <= 1;
        end else begin
            pc <= pc + 1;
            hc <= hc + 1;
        end
        if (!(oe && pin) && last)
            high_len <= hc;
        last <= oe && pin;
    end
endmodule // tbp_load

// ---- testbench/tb.sv ----
// self-checking bench for the pwm generator
`include "tbp_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, sys_rst = 1, sleep = 0, en = 0, pol = 0, dir = 1, fclr = 0;
    logic [2:0] run = 0;
    logic [1:0] src = 0, pre = 0;
    logic [7:0] pr = 0;
    logic [9:0] dut = 0;
    logic [2:0] flag;
    logic [7:0] cnt;
    logic pin, oe;
    int hi, per, errors = 0, n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    tbp_pwm uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sleep(sleep), .timer_run_bit(run),
        .timer_prescale_select({3{pre}}), .period_register({3{pr}}), .timer_source_select(src),
        .duty_high_byte(dut[9:2]), .duty_low_bits({dut[1:0], 6'h00}), .module_enable_bit(en),
        .output_polarity_bit(pol), .pin_direction_bit(dir), .timebase_flag_clear(fclr),
        .timebase_match_flag(flag), .timebase_counter(cnt), .pulse_output_pin(pin),
        .pulse_output_oe(oe));
    tbp_load u_load (.clk_sys(clk_sys), .pin(pin), .oe(oe), .high_len(hi), .period_len(per));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic [1:0] s, p, input logic [7:0] r, input logic [9:0] d,
        input logic pl);
        sys_rst <= 1;
        en <= 0;
        dir <= 1;
        run <= 0;
        repeat (2) @(posedge clk_sys);
        #1 chk(oe, 0);
        chk(flag, 0);
        @(posedge clk_sys);
        sys_rst <= 0;
        pol <= pl;
        src <= s;
        pr <= r;
        dut <= d;
        pre <= p;
        fclr <= 1;
        @(posedge clk_sys);
        fclr <= 0;
        run <= 3'h7;
        for (int i = 0; i < 3000 && flag[s] !== 1'b1; i++) @(posedge clk_sys);
        dir <= 0;
        en <= 1;
    endtask
    task automatic meas(input int p, h);
        repeat (3 * p + 4) @(posedge clk_sys);
        #1 chk(per, p);
        chk(hi, h);
        $display("test done at %0t", $time);
        @(posedge clk_sys);
    endtask
    task automatic hold(input int n, input logic ep, input logic frz);
        logic [7:0] c0;
        logic p0;
        #1 c0 = cnt;
        p0 = pin;
        repeat (n) begin
            @(posedge clk_sys);
            #1 chk(pin, frz ? p0 : ep);
            if (frz)
                chk(cnt, c0);
        end
        $display("test done at %0t", $time);
        @(posedge clk_sys);
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        wrap_up();
    end
    initial begin
        cfg(0, `TBP_PRESCALE_1, 8'h00, 10'h002, 0);
        meas(4, 2);
        cfg(1, `TBP_PRESCALE_4, 8'h03, 10'h009, 0);
        meas(64, 36);
        cfg(2, `TBP_PRESCALE_16, 8'h01, 10'h007, 0);
        meas(128, 112);
        cfg(1, `TBP_PRESCALE_1, 8'h07, 10'h00a, 1);
        meas(32, 22);
        cfg(0, `TBP_PRESCALE_1, 8'h00, 10'h000, 0);
        hold(12, 0, 0);
        cfg(0, `TBP_PRESCALE_1, 8'h00, 10'h005, 0);
        repeat (8) @(posedge clk_sys);
        hold(12, 1, 0);
        cfg(0, `TBP_PRESCALE_1, 8'h03, 10'h009, 0);
        repeat (5) @(posedge clk_sys);
        sleep <= 1;
        @(posedge clk_sys);
        hold(20, 0, 1);
        sleep <= 0;
        meas(16, 9);
        wrap_up();
    end
endmodule // tb
